// file: debi_mem.sv
// Behavioural external memory with a chosen number of wait states
`timescale 1ns/1ps
`default_nettype none
module debi_mem (
  // Bus from the device
  input  wire logic        clock_i,
  input  wire logic        strobe_n_i,
  input  wire logic        rd_wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  wait_i,
  // Answer
  output logic             ready_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [256];
  logic [1:0]  cnt;
  logic [15:0] last = 16'h0;
  // Ready withheld until the wait count runs out
  assign ready_o = !strobe_n_i && cnt == wait_i;
  // Idle bus shows the inverse so a stale word never matches
  assign rdata_o = (!strobe_n_i && rd_wr_i) ? mem[addr_i[7:0]] : ~last;
  always @(posedge clock_i) begin
    cnt <= (strobe_n_i || ready_o) ? 2'h0 : cnt + 2'h1;
    if (!strobe_n_i && rd_wr_i) last <= mem[addr_i[7:0]];
    if (ready_o && !rd_wr_i) mem[addr_i[7:0]] <= wdata_i;
  end
endmodule // debi_mem
`default_nettype wire

// file: debi_pkg.sv
// Types shared by the external bus interface
package debi_pkg;
  typedef enum logic [1:0] {
    DEBI_SP_PROG = 2'b00,
    DEBI_SP_DATA = 2'b01,
    DEBI_SP_IO   = 2'b10
  } debi_space_t;
  typedef enum logic [2:0] {
    DEBI_IDLE    = 3'b000,
    DEBI_ACCESS  = 3'b001,
    DEBI_DONE    = 3'b011,
    DEBI_HOLDREL = 3'b010,
    DEBI_HELD    = 3'b110,
    DEBI_UNGRANT = 3'b100
  } debi_state_t;
  typedef enum logic [1:0] {
    DEBI_MMR_NONE = 2'b00,
    DEBI_MMR_SEL  = 2'b01
  } debi_mmr_t;
endpackage

// file: debi_regs.svh
// Address map, bus widths and region register reset value of the external bus interface
`ifndef DEBI_REGS_SVH
`define DEBI_REGS_SVH
`define DEBI_AW            16
`define DEBI_DW            16
`define DEBI_B0_LO         16'h0200
`define DEBI_B0_HI         16'h02ff
`define DEBI_B0_PROG_LO    16'hff00
`define DEBI_B0_PROG_HI    16'hffff
`define DEBI_B1_LO         16'h0300
`define DEBI_B1_HI         16'h03ff
`define DEBI_B2_LO         16'h0060
`define DEBI_B2_HI         16'h007f
`define DEBI_MMR_HI        16'h0005
`define DEBI_DRR_ADDR      16'h0000
`define DEBI_DXR_ADDR      16'h0001
`define DEBI_TIM_ADDR      16'h0002
`define DEBI_PRD_ADDR      16'h0003
`define DEBI_IMR_ADDR      16'h0004
`define DEBI_GLOBAL_REGION_SIZE_REG_ADDR     16'h0005
`define DEBI_ROM_HI        16'h0fff
`define DEBI_GLOBAL_REGION_SIZE_REG_RESET    8'h00
`endif

// file: debi_top.sv
// External memory and I/O bus interface of a 16-bit signal processor
`timescale 1ns/1ps
`default_nettype none
`include "debi_regs.svh"
// Notes on behaviour
// - An external access stalls the core until ready is seen high.
// - On-chip RAM, ROM and fast memory complete with no wait state.
// - Program, data and I/O are separate spaces, 64K words each.
// - I/O uses the same buses and cycle as memory; only the space select differs.
// - Blocks one and two are always data; block zero is data or program.
// - The two map commands place block zero in data or program space.
// - External program fetches stay possible in either placement.
// - Six peripheral registers are decoded low in data space.
// - Interrupts wait until a multi-cycle or repeated access ends.
// - An 8-bit region register sizes the global data region.
// - An external data access inside the global region asserts the bus request.
// - On takeover, pins float and then the grant is asserted.
// - On-chip accesses continue while the bus is taken over.
module debi_top
  import debi_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_n_i,
  // Core request
  input  wire logic                 req_i,
  input  wire logic                 req_write_i,
  input  wire logic [1:0]           req_space_i,
  input  wire logic [`DEBI_AW-1:0]  req_addr_i,
  input  wire logic [`DEBI_DW-1:0]  req_wdata_i,
  input  wire logic                 map_block0_to_data_i,
  input  wire logic                 map_block0_to_program_i,
  input  wire logic                 multicycle_i,
  input  wire logic                 irq_pending_i,
  // Core answer
  output logic                      stall_o,
  output logic                      done_o,
  output logic [`DEBI_DW-1:0]       rdata_o,
  output logic                      onchip_hit_o,
  output logic                      block0_in_prog_o,
  output logic [2:0]                mmr_sel_o,
  output logic                      mmr_hit_o,
  output logic                      irq_take_o,
  // External bus
  output logic [`DEBI_AW-1:0]       addr_o,
  output logic                      addr_oe_o,
  input  wire logic [`DEBI_DW-1:0]  data_i,
  output logic [`DEBI_DW-1:0]       data_o,
  output logic                      data_oe_o,
  output logic                      prog_sel_n_o,
  output logic                      data_sel_n_o,
  output logic                      io_sel_n_o,
  output logic                      strobe_n_o,
  output logic                      rd_wr_o,
  output logic                      ctrl_oe_o,
  input  wire logic                 ready_i,
  output logic                      global_bus_request_n_o,
  input  wire logic                 takeover_req_n_i,
  output logic                      takeover_grant_n_o
);

  debi_state_t          state, next_state;
  logic [7:0]           global_region_size_reg, next_global_region_size_reg;
  logic                 b0_prog, next_b0_prog;
  logic [`DEBI_AW-1:0]  next_addr;
  logic [`DEBI_DW-1:0]  next_data, next_rdata;
  logic                 next_data_oe, next_oe, next_strobe_n, next_rd_wr;
  logic                 next_prog_n, next_data_n, next_io_n, next_br_n;
  logic                 next_grant_n, next_stall, next_done, next_onchip;
  logic [2:0]           next_mmr_sel;
  logic                 next_mmr_hit, next_irq_take;
  logic                 is_onchip, is_mmr, in_global;
  logic [`DEBI_AW-1:0]  global_base;

  // Address decoding for the current request
  always_comb begin
    is_onchip   = 1'b0;
    is_mmr      = 1'b0;
    global_base = 16'hffff - {global_region_size_reg, 8'hff};
    if (req_space_i == DEBI_SP_IO) begin
      is_onchip = 1'b0;
    end else if (req_space_i == DEBI_SP_DATA &&
                 req_addr_i <= `DEBI_MMR_HI) begin
      is_onchip = 1'b1;
      is_mmr    = 1'b1;
    end else if (req_space_i == DEBI_SP_DATA &&
                 ((req_addr_i >= `DEBI_B1_LO && req_addr_i <= `DEBI_B1_HI) ||
                  (req_addr_i >= `DEBI_B2_LO &&
                   req_addr_i <= `DEBI_B2_HI))) begin
      is_onchip = 1'b1;
    end else if (req_space_i == DEBI_SP_DATA && !b0_prog &&
                 req_addr_i >= `DEBI_B0_LO && req_addr_i <= `DEBI_B0_HI) begin
      is_onchip = 1'b1;
    end else if (req_space_i == DEBI_SP_PROG && b0_prog &&
                 req_addr_i >= `DEBI_B0_PROG_LO) begin
      is_onchip = 1'b1;
    end else if (req_space_i == DEBI_SP_PROG &&
                 req_addr_i <= `DEBI_ROM_HI) begin
      is_onchip = 1'b1;
    end
    // Region grows down from the top of data space; zero means none
    in_global = (req_space_i == DEBI_SP_DATA) &&
                (global_region_size_reg != 8'h00) &&
                (req_addr_i > global_base);
  end

  // Bus sequencing, placement and region register
  always_comb begin
    next_state    = state;
    next_global_region_size_reg     = global_region_size_reg;
    next_b0_prog  = b0_prog;
    next_addr     = addr_o;
    next_data     = data_o;
    next_rdata    = rdata_o;
    next_data_oe  = data_oe_o;
    next_oe       = addr_oe_o;
    next_strobe_n = 1'b1;
    next_rd_wr    = rd_wr_o;
    next_prog_n   = 1'b1;
    next_data_n   = 1'b1;
    next_io_n     = 1'b1;
    next_br_n     = 1'b1;
    next_grant_n  = takeover_grant_n_o;
    next_stall    = 1'b0;
    next_done     = 1'b0;
    next_onchip   = 1'b0;
    next_mmr_sel  = mmr_sel_o;
    next_mmr_hit  = 1'b0;
    if (map_block0_to_data_i) begin
      next_b0_prog = 1'b0;
    end else if (map_block0_to_program_i) begin
      next_b0_prog = 1'b1;
    end
    case (state)
      DEBI_IDLE, DEBI_HELD: begin
        if (state == DEBI_IDLE && !takeover_req_n_i) begin
          // Float first, grant next cycle
          next_oe      = 1'b0;
          next_data_oe = 1'b0;
          next_state   = DEBI_HOLDREL;
        end else if (state == DEBI_HELD && takeover_req_n_i) begin
          next_grant_n = 1'b1;
          next_state   = DEBI_UNGRANT;
        end else if (req_i && is_onchip) begin
          next_done    = 1'b1;
          next_onchip  = 1'b1;
          next_mmr_hit = is_mmr;
          next_mmr_sel = req_addr_i[2:0];
          if (req_write_i && is_mmr &&
              req_addr_i == `DEBI_GLOBAL_REGION_SIZE_REG_ADDR) begin
            next_global_region_size_reg = req_wdata_i[7:0];
          end
        end else if (req_i && state == DEBI_IDLE) begin
          next_addr     = req_addr_i;
          next_rd_wr    = !req_write_i;
          next_data     = req_wdata_i;
          next_data_oe  = req_write_i;
          next_strobe_n = 1'b0;
          next_prog_n   = (req_space_i != DEBI_SP_PROG);
          next_data_n   = (req_space_i != DEBI_SP_DATA);
          next_io_n     = (req_space_i != DEBI_SP_IO);
          next_br_n     = !in_global;
          next_stall    = 1'b1;
          next_state    = DEBI_ACCESS;
        end else if (req_i) begin
          next_stall = 1'b1;
        end
      end
      DEBI_ACCESS: begin
        next_strobe_n = 1'b0;
        next_prog_n   = prog_sel_n_o;
        next_data_n   = data_sel_n_o;
        next_io_n     = io_sel_n_o;
        next_br_n     = global_bus_request_n_o;
        next_stall    = 1'b1;
        if (ready_i) begin
          // Ready sampled high closes the cycle
          next_rdata    = data_i;
          next_strobe_n = 1'b1;
          next_data_oe  = 1'b0;
          next_state    = DEBI_DONE;
        end
      end
      DEBI_DONE: begin
        next_stall = 1'b0;
        next_done  = 1'b1;
        next_state = DEBI_IDLE;
      end
      DEBI_HOLDREL: begin
        next_grant_n = 1'b0;
        next_state   = DEBI_HELD;
      end
      DEBI_UNGRANT: begin
        // Pins return only after grant is high
        next_oe    = 1'b1;
        next_state = DEBI_IDLE;
      end
      default: next_state = DEBI_IDLE;
    endcase
    // Interrupts only between whole accesses
    next_irq_take = irq_pending_i && !multicycle_i &&
                    (next_state == DEBI_IDLE || next_state == DEBI_HELD) &&
                    !next_stall;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state                  <= DEBI_IDLE;
      global_region_size_reg <= `DEBI_GLOBAL_REGION_SIZE_REG_RESET;
      b0_prog                <= 1'b0;
      addr_o                 <= 16'h0000;
      addr_oe_o              <= 1'b1;
      ctrl_oe_o              <= 1'b1;
      data_o                 <= 16'h0000;
      data_oe_o              <= 1'b0;
      rdata_o                <= 16'h0000;
      strobe_n_o             <= 1'b1;
      rd_wr_o                <= 1'b1;
      prog_sel_n_o           <= 1'b1;
      data_sel_n_o           <= 1'b1;
      io_sel_n_o             <= 1'b1;
      global_bus_request_n_o <= 1'b1;
      takeover_grant_n_o     <= 1'b1;
      stall_o                <= 1'b0;
      done_o                 <= 1'b0;
      onchip_hit_o           <= 1'b0;
      mmr_sel_o              <= 3'h0;
      mmr_hit_o              <= 1'b0;
      irq_take_o             <= 1'b0;
    end else begin
      state                  <= next_state;
      global_region_size_reg <= next_global_region_size_reg;
      b0_prog                <= next_b0_prog;
      addr_o                 <= next_addr;
      addr_oe_o              <= next_oe;
      ctrl_oe_o              <= next_oe;
      data_o                 <= next_data;
      data_oe_o              <= next_data_oe;
      rdata_o                <= next_rdata;
      strobe_n_o             <= next_strobe_n;
      rd_wr_o                <= next_rd_wr;
      prog_sel_n_o           <= next_prog_n;
      data_sel_n_o           <= next_data_n;
      io_sel_n_o             <= next_io_n;
      global_bus_request_n_o <= next_br_n;
      takeover_grant_n_o     <= next_grant_n;
      stall_o                <= next_stall;
      done_o                 <= next_done;
      onchip_hit_o           <= next_onchip;
      mmr_sel_o              <= next_mmr_sel;
      mmr_hit_o              <= next_mmr_hit;
      irq_take_o             <= next_irq_take;
    end
  end

  assign block0_in_prog_o = b0_prog;

endmodule // debi_top
`default_nettype wire

// file: debi_top_sva.sv
// Pin timing checks for the external bus interface
`timescale 1ns/1ps
`default_nettype none
module debi_top_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Core side
  input wire logic multicycle_i,
  input wire logic stall_o,
  input wire logic done_o,
  input wire logic onchip_hit_o,
  input wire logic irq_take_o,
  // Bus side
  input wire logic ready_i,
  input wire logic strobe_n_o,
  input wire logic prog_sel_n_o,
  input wire logic data_sel_n_o,
  input wire logic io_sel_n_o,
  input wire logic addr_oe_o,
  input wire logic ctrl_oe_o,
  input wire logic data_oe_o,
  input wire logic global_bus_request_n_o,
  input wire logic takeover_grant_n_o
);
  default clocking dcb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  a_wait_for_ready: assert property (!strobe_n_o && !ready_i |=> !strobe_n_o)
    else $error("bus cycle closed without ready");
  a_done_after_ready: assert property (!strobe_n_o && ready_i |=>
    strobe_n_o ##1 done_o) else $error("no done after ready");
  a_fast_onchip: assert property (onchip_hit_o |-> done_o && !stall_o)
    else $error("on-chip access stalled");
  a_one_space: assert property (!strobe_n_o |->
    $onehot(~{prog_sel_n_o, data_sel_n_o, io_sel_n_o}))
    else $error("space select not unique");
  // Two cycles so either latency of the gate is accepted
  a_irq_deferred: assert property ((stall_o || multicycle_i) [*2] |->
    !irq_take_o) else $error("interrupt taken mid instruction");
  a_held_floats: assert property (!takeover_grant_n_o |->
    !addr_oe_o && !data_oe_o && !ctrl_oe_o && strobe_n_o)
    else $error("driving while held");
  a_float_first: assert property ($fell(takeover_grant_n_o) |->
    !$past(addr_oe_o)) else $error("grant before pins floated");
  a_grant_first: assert property ($rose(addr_oe_o) |->
    $past(takeover_grant_n_o)) else $error("pins driven before grant drop");
  c_ready: cover property (!strobe_n_o && ready_i);
  c_grant: cover property ($fell(takeover_grant_n_o));
  c_global: cover property (!global_bus_request_n_o);
endmodule // debi_top_sva
bind debi_top debi_top_sva i_sva (.*);
`default_nettype wire

// file: dsp_external_bus_interface_tb.sv
// Self-checking bench for the external bus interface
`timescale 1ns/1ps
`default_nettype none
`include "debi_regs.svh"
module dsp_external_bus_interface_tb;
  logic clock_i = 0, reset_n_i = 0, req_i = 0, req_write_i = 0;
  logic multicycle_i = 0, irq_pending_i = 1, takeover_req_n_i = 1;
  logic map_block0_to_data_i = 0, map_block0_to_program_i = 0, br_seen;
  logic stall_o, done_o, onchip_hit_o, block0_in_prog_o, mmr_hit_o;
  logic irq_take_o, addr_oe_o, data_oe_o, prog_sel_n_o, data_sel_n_o;
  logic io_sel_n_o, strobe_n_o, rd_wr_o, ctrl_oe_o, ready_i;
  logic global_bus_request_n_o, takeover_grant_n_o;
  logic [1:0] req_space_i = 0, wait_cyc = 0;
  logic [2:0] mmr_sel_o;
  logic [15:0] req_addr_i = 0, req_wdata_i = 0, rdata_o, addr_o;
  logic [15:0] data_o, data_i, mem_q;
  logic [31:0] seed = 32'h824c41d7;
  int n_fail = 0, total_checks = 0;
  assign data_i = data_oe_o ? data_o : mem_q;
  always #5 clock_i = ~clock_i;
  debi_top i_dut (.*);
  debi_mem i_mem (.clock_i, .strobe_n_i(strobe_n_o), .rd_wr_i(rd_wr_o),
    .addr_i(addr_o), .wdata_i(data_o), .wait_i(wait_cyc),
    .ready_o(ready_i), .rdata_o(mem_q));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until the edge that raises done
  task automatic acc(logic wr, logic [1:0] sp, logic [15:0] a, d, logic fast);
    logic seen;
    seen = 0;
    br_seen = 0;
    @(posedge clock_i);
    req_i <= 1;
    req_write_i <= wr;
    req_space_i <= sp;
    req_addr_i <= a;
    req_wdata_i <= d;
    wait_cyc <= 2'(rnd());
    for (int i = 0; i < 40 && !fast; i++) begin
      @(posedge clock_i);
      if (seen && strobe_n_o) break;
      if (!strobe_n_o) begin
        seen = 1;
        br_seen |= !global_bus_request_n_o;
        chk("sel", {io_sel_n_o, data_sel_n_o, prog_sel_n_o},
          16'h7 ^ (16'h1 << sp));
        chk("addr", addr_o, a);
        chk("drive", {stall_o, rd_wr_o, data_oe_o}, {1'b1, !wr, wr});
      end
    end
    if (fast) @(posedge clock_i);
    req_i <= 0;
    #1 chk("done", {done_o, onchip_hit_o}, {fast, fast} | 16'h2);
    if (!wr && !fast) chk("rdata", rdata_o, d);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    logic [1:0] sp;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1;
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      sp = r[17:16] % 2'h3;
      acc(1, sp, {1'b0, r[14:12] | 3'h1, r[11:0]}, r[31:16], 0);
      acc(0, sp, {1'b0, r[14:12] | 3'h1, r[11:0]}, r[31:16], 0);
    end
    acc(0, 2'h0, 16'h0010, 16'h0, 1);
    acc(1, 2'h1, `DEBI_B1_LO, 16'h1, 1);
    acc(1, 2'h1, `DEBI_B2_HI, 16'h1, 1);
    acc(1, 2'h1, `DEBI_GLOBAL_REGION_SIZE_REG_ADDR, 16'h0001, 1);
    chk("mmr", {mmr_hit_o, mmr_sel_o}, 16'hd);
    // Region of size one starts just above fe00
    acc(1, 2'h1, 16'hfe00, 16'h5, 0);
    chk("br out", br_seen, 0);
    acc(1, 2'h1, 16'hfe01, 16'h5, 0);
    chk("br in", br_seen, 1);
    @(posedge clock_i) map_block0_to_program_i <= 1;
    @(posedge clock_i) map_block0_to_program_i <= 0;
    #1 chk("b0 prog", block0_in_prog_o, 1);
    acc(0, 2'h0, `DEBI_B0_PROG_LO, 16'h0, 1);
    acc(1, 2'h0, 16'h2000, 16'h77, 0);
    acc(0, 2'h0, 16'h2000, 16'h77, 0);
    @(posedge clock_i) map_block0_to_data_i <= 1;
    @(posedge clock_i) map_block0_to_data_i <= 0;
    #1 chk("b0 data", block0_in_prog_o, 0);
    acc(1, 2'h1, `DEBI_B0_LO, 16'h1, 1);
    @(posedge clock_i) takeover_req_n_i <= 0;
    repeat (3) @(posedge clock_i);
    #1 chk("held", {takeover_grant_n_o, addr_oe_o, data_oe_o, ctrl_oe_o},
      0);
    acc(0, 2'h0, 16'h0020, 16'h0, 1);
    // External access while held must wait, not run
    @(posedge clock_i) begin
      req_i <= 1;
      req_space_i <= 2'h1;
      req_addr_i <= 16'h1234;
    end
    @(posedge clock_i);
    @(posedge clock_i) req_i <= 0;
    #1 chk("held wait", {stall_o, strobe_n_o, done_o}, 16'h6);
    @(posedge clock_i) takeover_req_n_i <= 1;
    repeat (3) @(posedge clock_i);
    #1 chk("released", {takeover_grant_n_o, addr_oe_o, ctrl_oe_o},
      16'h7);
    @(posedge clock_i) multicycle_i <= 1;
    repeat (3) @(posedge clock_i);
    #1 chk("irq wait", irq_take_o, 0);
    @(posedge clock_i) multicycle_i <= 0;
    repeat (3) @(posedge clock_i);
    #1 chk("irq take", irq_take_o, 1);
    test_done();
  end
endmodule // dsp_external_bus_interface_tb
`default_nettype wire
